// [hdl/line_coding_params.svh]
// constants of the fast ethernet transmit and receive line coding block
`ifndef LINE_CODING_PARAMS_SVH
`define LINE_CODING_PARAMS_SVH

// code-group size and serial bit position
`define CG_WIDTH        5
`define CG_MSB          4
`define NIBBLE_WIDTH    4
`define BIT_COUNT_LAST  3'h4
`define BIT_COUNT_FIRST 3'h0

// control code-groups, sent msb first
`define CG_IDLE         5'h1f
`define CG_START_J      5'h18
`define CG_START_K      5'h11
`define CG_END_T        5'h0d
`define CG_END_R        5'h07

// data code-groups, entry n at bits [5n+4:5n], nibble 0 lowest
`define CG_DATA_TABLE   80'hef37abda727b96aad13e

// scrambler: 11-bit lfsr, feedback from bits 10 and 8 (x^11 + x^9 + 1)
`define SCR_WIDTH       11
`define SCR_TAP_A       10
`define SCR_TAP_B       8
`define SCR_SEED_HIGH   6'h3f

// three-level line phases
`define MLT_ZERO_A      2'h0
`define MLT_PLUS        2'h1
`define MLT_ZERO_B      2'h2
`define MLT_MINUS       2'h3

// signal detect qualification: gap in bit times, qualify count in transitions
`define SD_MAX_GAP      8'h20
`define SD_QUALIFY      8'h80
`define SD_COUNT_ZERO   8'h00
`define SD_COUNT_ONE    8'h01

`endif

// [hdl/line_coding_pkg.sv]
// types shared by the line coding block
package line_coding_pkg;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_J    = 3'b001,
        TX_DATA = 3'b010,
        TX_T    = 3'b011,
        TX_R    = 3'b100
    } tx_state_t;

    typedef struct packed {
        logic       en;
        logic [3:0] data;
    } mac_word_t;

endpackage : line_coding_pkg

// [hdl/nibble_fifo.sv]
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps

module nibble_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("nibble_fifo: DEPTH must be a power of two >= 2");
        end
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr_ptr;
        logic [AW:0]                 rd_ptr;
        logic                        not_full;
        logic                        not_empty;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;

    logic        push;
    logic        pop;
    logic [AW:0] used;

    always_comb begin
        next_st = st;
        push    = in_valid && st.not_full;
        pop     = out_ready && st.not_empty;
        if (push) begin
            next_st.mem[st.wr_ptr[AW-1:0]] = in_data;
            next_st.wr_ptr = st.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_st.rd_ptr = st.rd_ptr + 1'b1;
        end
        used = next_st.wr_ptr - next_st.rd_ptr;
        next_st.not_full  = (used != (AW+1)'(DEPTH));
        next_st.not_empty = (used != '0);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready  = st.not_full;
    assign out_valid = st.not_empty;
    assign out_data  = st.mem[st.rd_ptr[AW-1:0]];

endmodule : nibble_fifo

// [hdl/fast_ethernet_tx_line_coding.sv]
// 100 Mb/s line coding: 4b/5b encode, scramble, nrzi, three-level out; receive decode
`timescale 1ns/1ps
`include "line_coding_params.svh"

// What this block does
// - frame start sends J then K code-groups
// - later nibbles become their 5b code-groups
// - enable drop appends T then R
// - idle code-groups fill until next frame
// - scrambler is 11-bit closed loop lfsr
// - each encoded bit xored with scrambler output
// - scrambler seed taken from address straps
// - scrambled stream is nrzi encoded
// - ones step two driver streams through plus, zero, minus, zero
// - only three-level output at 100 Mb/s
// - link pulses never raise signal detect
// - three-level decisions become nrzi bits
// - nrzi decoded to nrz, with no descrambling
// - nrz deserialized into 5-bit symbols
// - idle code-group is all ones
module fast_ethernet_tx_line_coding #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // mac transmit nibbles
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic       tx_en,
    input  wire logic [3:0] txd,
    // address straps
    input  wire logic [4:0] phy_address_straps,
    // three-level driver streams
    output logic            mlt_pos,
    output logic            mlt_neg,
    // equalized three-level decisions
    input  wire logic       rx_level_pos,
    input  wire logic       rx_level_neg,
    // receive symbols
    output logic            signal_detect,
    output logic [4:0]      rx_symbol,
    output logic            rx_symbol_valid
);

    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("fast_ethernet_tx_line_coding: FIFO_DEPTH must be at least 2");
        end
    end

    typedef struct packed {
        // strap synchroniser and seeding
        logic [4:0]                  strap_s1;
        logic [4:0]                  strap_s2;
        logic [4:0]                  strap_s3;
        logic                        seeded;
        // transmit path
        line_coding_pkg::tx_state_t  tx_state;
        logic [`CG_WIDTH-1:0]        tx_shift;
        logic [2:0]                  tx_count;
        logic [`SCR_WIDTH-1:0]       lfsr;
        logic                        tx_nrzi;
        logic [1:0]                  mlt_phase;
        logic                        mlt_pos;
        logic                        mlt_neg;
        // receive path
        logic [1:0]                  rx_prev_level;
        logic                        rx_nrzi;
        logic                        rx_nrzi_prev;
        logic [`CG_WIDTH-1:0]        rx_shift;
        logic [2:0]                  rx_count;
        logic [`CG_WIDTH-1:0]        rx_symbol;
        logic                        rx_symbol_valid;
        logic [7:0]                  gap_count;
        logic [7:0]                  active_count;
        logic                        signal_detect;
    } state_t;

    state_t st;
    state_t next_st;

    // fifo between the mac and the encoder
    line_coding_pkg::mac_word_t fifo_in;
    line_coding_pkg::mac_word_t fifo_out;
    logic                       fifo_in_ready;
    logic                       fifo_out_valid;
    logic                       fifo_pop;

    assign fifo_in.en   = tx_en;
    assign fifo_in.data = txd;

    nibble_fifo #(
        .WIDTH (`CG_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (tx_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    // combinational working values
    logic                 boundary;
    logic [`CG_WIDTH-1:0] next_group;
    logic                 enc_bit;
    logic                 scr_key;
    logic                 scr_bit;
    logic [1:0]           level_now;
    logic                 rx_transition;
    logic                 rx_nrz;
    logic [79:0]          data_table;

    always_comb begin
        next_st       = st;
        fifo_pop      = 1'b0;
        next_group    = `CG_IDLE;
        data_table    = `CG_DATA_TABLE;
        boundary      = (st.tx_count == `BIT_COUNT_LAST);
        enc_bit       = st.tx_shift[`CG_MSB];
        scr_key       = st.lfsr[`SCR_TAP_A] ^ st.lfsr[`SCR_TAP_B];
        scr_bit       = enc_bit ^ scr_key;
        level_now     = {rx_level_pos, rx_level_neg};
        rx_transition = (level_now != st.rx_prev_level);
        rx_nrz        = st.rx_nrzi ^ st.rx_nrzi_prev;

        // straps: three flops, value counts once the last two agree
        next_st.strap_s1 = phy_address_straps;
        next_st.strap_s2 = st.strap_s1;
        next_st.strap_s3 = st.strap_s2;

        if (!st.seeded) begin
            // line stays at zero until the scrambler holds its seed
            if (st.strap_s2 == st.strap_s3) begin
                next_st.lfsr   = {`SCR_SEED_HIGH, st.strap_s3};
                next_st.seeded = 1'b1;
            end
        end else begin
            // ---- serial transmit, one bit per clock ----
            next_st.lfsr = {st.lfsr[`SCR_WIDTH-2:0], scr_key};
            if (scr_bit) begin
                next_st.tx_nrzi   = ~st.tx_nrzi;
                next_st.mlt_phase = st.mlt_phase + 2'h1;
            end
            // two driver streams, ones step the line plus, zero, minus, zero
            next_st.mlt_pos = (next_st.mlt_phase == `MLT_PLUS);
            next_st.mlt_neg = (next_st.mlt_phase == `MLT_MINUS);

            if (boundary) begin
                next_st.tx_count = `BIT_COUNT_FIRST;
                case (st.tx_state)
                    line_coding_pkg::TX_IDLE: begin
                        if (fifo_out_valid && fifo_out.en) begin
                            // first preamble nibble is replaced by J
                            fifo_pop         = 1'b1;
                            next_group       = `CG_START_J;
                            next_st.tx_state = line_coding_pkg::TX_J;
                        end else begin
                            // words outside a frame are dropped
                            fifo_pop   = fifo_out_valid;
                            next_group = `CG_IDLE;
                        end
                    end
                    line_coding_pkg::TX_J: begin
                        // second preamble nibble is replaced by K
                        fifo_pop         = fifo_out_valid;
                        next_group       = `CG_START_K;
                        next_st.tx_state = line_coding_pkg::TX_DATA;
                    end
                    line_coding_pkg::TX_DATA: begin
                        if (fifo_out_valid && fifo_out.en) begin
                            fifo_pop   = 1'b1;
                            next_group = data_table[fifo_out.data * `CG_WIDTH +: `CG_WIDTH];
                        end else begin
                            // enable dropped, or fifo ran dry: close the frame
                            fifo_pop         = fifo_out_valid;
                            next_group       = `CG_END_T;
                            next_st.tx_state = line_coding_pkg::TX_T;
                        end
                    end
                    line_coding_pkg::TX_T: begin
                        next_group       = `CG_END_R;
                        next_st.tx_state = line_coding_pkg::TX_R;
                    end
                    line_coding_pkg::TX_R: begin
                        // at least one idle follows every end delimiter
                        next_group       = `CG_IDLE;
                        next_st.tx_state = line_coding_pkg::TX_IDLE;
                    end
                    default: begin
                        next_group       = `CG_IDLE;
                        next_st.tx_state = line_coding_pkg::TX_IDLE;
                    end
                endcase
                next_st.tx_shift = next_group;
            end else begin
                next_st.tx_count = st.tx_count + 3'h1;
                next_st.tx_shift = {st.tx_shift[`CG_MSB-1:0], 1'b0};
            end
        end

        // ---- receive: three-level to nrzi to nrz ----
        next_st.rx_prev_level = level_now;
        if (rx_transition) begin
            next_st.rx_nrzi = ~st.rx_nrzi;
        end
        next_st.rx_nrzi_prev = st.rx_nrzi;

        // deserialize nrz into 5-bit symbols
        next_st.rx_shift        = {st.rx_shift[`CG_MSB-1:0], rx_nrz};
        next_st.rx_symbol_valid = 1'b0;
        if (st.rx_count == `BIT_COUNT_LAST) begin
            next_st.rx_count        = `BIT_COUNT_FIRST;
            next_st.rx_symbol       = next_st.rx_shift;
            next_st.rx_symbol_valid = 1'b1;
        end else begin
            next_st.rx_count = st.rx_count + 3'h1;
        end

        // signal detect needs a long run of dense transitions;
        // an isolated link pulse restarts the qualification
        if (rx_transition) begin
            next_st.gap_count = `SD_COUNT_ZERO;
            if (st.active_count != `SD_QUALIFY) begin
                next_st.active_count = st.active_count + `SD_COUNT_ONE;
            end
        end else if (st.gap_count != `SD_MAX_GAP) begin
            next_st.gap_count = st.gap_count + `SD_COUNT_ONE;
        end else begin
            next_st.active_count = `SD_COUNT_ZERO;
        end
        next_st.signal_detect = (next_st.active_count == `SD_QUALIFY) &&
                                (next_st.gap_count != `SD_MAX_GAP);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st          <= '0;
            st.tx_shift <= `CG_IDLE;
            // straps keep settling through reset so the seed sees real pins
            st.strap_s1 <= phy_address_straps;
            st.strap_s2 <= st.strap_s1;
            st.strap_s3 <= st.strap_s2;
        end else begin
            st <= next_st;
        end
    end

    // outputs, each from a flop
    assign tx_ready        = fifo_in_ready;
    assign mlt_pos         = st.mlt_pos;
    assign mlt_neg         = st.mlt_neg;
    assign signal_detect   = st.signal_detect;
    assign rx_symbol       = st.rx_symbol;
    assign rx_symbol_valid = st.rx_symbol_valid;

endmodule : fast_ethernet_tx_line_coding

// [verif/line_coding_sva.sv]
// port assertions for the line coding block
`timescale 1ns/1ps

module line_coding_sva #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // mac side
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    input wire logic       tx_en,
    input wire logic [3:0] txd,
    input wire logic [4:0] phy_address_straps,
    // line side
    input wire logic       mlt_pos,
    input wire logic       mlt_neg,
    input wire logic       rx_level_pos,
    input wire logic       rx_level_neg,
    // receive symbols
    input wire logic       signal_detect,
    input wire logic [4:0] rx_symbol,
    input wire logic       rx_symbol_valid
);
    logic [1:0] prev_lvl;
    logic [7:0] chg_run;
    logic [7:0] quiet;
    logic       last_pos;
    logic       chg;

    assign chg = ({rx_level_pos, rx_level_neg} != prev_lvl);

    // run lengths of changing and still receive levels
    always_ff @(posedge clk) begin
        prev_lvl <= {rx_level_pos, rx_level_neg};
        chg_run  <= (reset || !chg) ? 8'h00 : chg_run + {7'h00, chg_run != 8'hff};
        quiet    <= (reset || chg) ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
        last_pos <= reset ? 1'b0 : (mlt_pos ? 1'b1 : (mlt_neg ? 1'b0 : last_pos));
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_drive_exclusive: assert property (!(mlt_pos && mlt_neg))
        else $error("both driver streams high");
    a_plus_via_zero: assert property (mlt_pos |=> !mlt_neg)
        else $error("line jumped from plus to minus");
    a_plus_alternates: assert property ($rose(mlt_pos) |-> !last_pos)
        else $error("two plus pulses in a row");
    a_minus_alternates: assert property ($rose(mlt_neg) |-> last_pos)
        else $error("two minus pulses in a row");
    a_symbol_spacing: assert property (rx_symbol_valid |=> !rx_symbol_valid [*4] ##1 rx_symbol_valid)
        else $error("symbol valid not every five clocks");
    a_symbol_holds: assert property ($changed(rx_symbol) |-> rx_symbol_valid)
        else $error("symbol changed without valid");
    a_changes_give_ones: assert property (chg_run >= 8'h0c && rx_symbol_valid |-> rx_symbol == 5'h1f)
        else $error("steady transitions not decoded as ones");
    a_still_gives_zeros: assert property (quiet >= 8'h0c && rx_symbol_valid |-> rx_symbol == 5'h00)
        else $error("still line not decoded as zeros");
    a_gap_drops_detect: assert property (quiet >= 8'h28 |-> !signal_detect)
        else $error("signal detect held over a long gap");
endmodule : line_coding_sva

// [verif/line_partner.sv]
// far side: receive level source and transmit descrambler that collects code-groups
`timescale 1ns/1ps

module line_partner (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // line side of the block
    input  wire logic       mlt_pos,
    input  wire logic       mlt_neg,
    output logic            rx_level_pos,
    output logic            rx_level_neg,
    // 0 still, 1 loopback, 2 toggle each bit, 3 link pulses
    input  wire logic [1:0] mode
);
    logic [1:0]  prev = 2'h0;
    logic [1:0]  ph = 2'h0;
    logic [6:0]  tick = 7'h00;
    logic [10:0] lfsr;
    logic [4:0]  run;
    logic [9:0]  hist;
    logic [2:0]  cnt;
    logic        in_frame;
    logic        s;
    logic        pred;
    logic        b;
    logic [4:0]  groups[$];

    always @(negedge clk) begin
        ph   <= ph + 2'h1;
        tick <= (tick == 7'h63) ? 7'h00 : tick + 7'h01;
        case (mode)
            2'h1: {rx_level_pos, rx_level_neg} <= {mlt_pos, mlt_neg};
            2'h2: {rx_level_pos, rx_level_neg} <= {ph == 2'h1, ph == 2'h3};
            2'h3: {rx_level_pos, rx_level_neg} <= {tick == 7'h00, 1'b0};
            default: {rx_level_pos, rx_level_neg} <= 2'h0;
        endcase
    end

    // locks on scrambled idle, then descrambles and frames on J/K
    always @(posedge clk) begin
        s    = ({mlt_pos, mlt_neg} != prev);
        pred = lfsr[10] ^ lfsr[8];
        b    = s ^ pred;
        prev = {mlt_pos, mlt_neg};
        if (reset) begin
            run      = 5'h00;
            in_frame = 1'b0;
            lfsr     = 11'h000;
        end else if (run < 5'h18) begin
            run  = (s != pred) ? run + 5'h01 : 5'h00;
            lfsr = {lfsr[9:0], ~s};
        end else begin
            lfsr = {lfsr[9:0], pred};
            hist = {hist[8:0], b};
            if (!in_frame && hist == 10'h311) begin
                groups.push_back(5'h18);
                groups.push_back(5'h11);
                in_frame = 1'b1;
                cnt      = 3'h0;
            end else if (in_frame) begin
                cnt = cnt + 3'h1;
                if (cnt == 3'h5) begin
                    groups.push_back(hist[4:0]);
                    cnt      = 3'h0;
                    in_frame = (hist[4:0] != 5'h1f);
                end
            end
        end
    end
endmodule : line_partner

// [verif/fast_ethernet_tx_line_coding_bench.sv]
// bench: frames out through the line model, level patterns back in
`timescale 1ns/1ps

module fast_ethernet_tx_line_coding_bench;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       tx_valid = 1'b0;
    logic       tx_en = 1'b0;
    logic [3:0] txd = 4'h0;
    logic [4:0] phy_address_straps = 5'h0a;
    logic [1:0] mode = 2'h1;
    logic       tx_ready;
    logic       mlt_pos;
    logic       mlt_neg;
    logic       rx_level_pos;
    logic       rx_level_neg;
    logic       signal_detect;
    logic [4:0] rx_symbol;
    logic       rx_symbol_valid;
    logic       refused;
    int         n_mismatch = 0;
    int         compares = 0;
    int         cycles = 0;
    logic [4:0] exp_q[$];
    localparam logic [4:0] code_tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
        5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    always #25 clk = ~clk;

    fast_ethernet_tx_line_coding #(.FIFO_DEPTH(4)) dut (.clk(clk), .reset(reset),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_en(tx_en), .txd(txd),
        .phy_address_straps(phy_address_straps), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg),
        .rx_level_pos(rx_level_pos), .rx_level_neg(rx_level_neg),
        .signal_detect(signal_detect), .rx_symbol(rx_symbol), .rx_symbol_valid(rx_symbol_valid));

    line_partner line (.clk(clk), .reset(reset), .mlt_pos(mlt_pos), .mlt_neg(mlt_neg),
        .rx_level_pos(rx_level_pos), .rx_level_neg(rx_level_neg), .mode(mode));

    task automatic print_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reset_dut(input logic [4:0] straps);
        @(negedge clk);
        reset = 1'b1;
        phy_address_straps = straps;
        repeat (8) @(negedge clk);
        reset = 1'b0;
        repeat (80) @(negedge clk);
    endtask : reset_dut

    // called at a falling edge; holds the word until the fifo takes it
    task automatic put(input logic en, input logic [3:0] d);
        tx_valid = 1'b1;
        tx_en    = en;
        txd      = d;
        while (tx_ready !== 1'b1) begin
            refused = 1'b1;
            @(negedge clk);
        end
        @(negedge clk);
    endtask : put

    task automatic expect_groups(input string what);
        int i;
        i = 0;
        while (line.groups.size() < exp_q.size() && i < 2000) begin
            @(negedge clk);
            i++;
        end
        check(what, 8'(exp_q.size()), 8'(line.groups.size()));
        foreach (exp_q[k]) check(what, {3'h0, exp_q[k]}, {3'h0, line.groups[k]});
        exp_q.delete();
        line.groups.delete();
    endtask : expect_groups

    task automatic t_all_codes;
        refused = 1'b0;
        exp_q = '{5'h18, 5'h11};
        put(1'b1, 4'h5);
        put(1'b1, 4'h5);
        for (int n = 0; n < 16; n++) begin
            put(1'b1, n[3:0]);
            exp_q.push_back(code_tab[n]);
        end
        put(1'b0, 4'h0);
        tx_valid = 1'b0;
        exp_q = {exp_q, 5'h0d, 5'h07, 5'h1f};
        expect_groups("all data groups");
        check("fifo refused when full", 8'h01, {7'h00, refused});
        check("fifo drained", 8'h01, {7'h00, tx_ready});
    endtask : t_all_codes

    task automatic t_back_to_back;
        put(1'b1, 4'h5);
        put(1'b1, 4'h5);
        put(1'b1, 4'h9);
        put(1'b1, 4'ha);
        put(1'b0, 4'h0);
        put(1'b1, 4'h5);
        put(1'b1, 4'h5);
        put(1'b1, 4'h3);
        tx_valid = 1'b0;
        exp_q = '{5'h18, 5'h11, 5'h13, 5'h16, 5'h0d, 5'h07, 5'h1f,
                  5'h18, 5'h11, 5'h15, 5'h0d, 5'h07, 5'h1f};
        expect_groups("two frames then underrun");
    endtask : t_back_to_back

    task automatic wait_valid;
        int i;
        i = 0;
        while (rx_symbol_valid !== 1'b1 && i < 10) begin
            @(negedge clk);
            i++;
        end
    endtask : wait_valid

    task automatic t_receive;
        int i;
        mode = 2'h2;
        repeat (20) @(negedge clk);
        wait_valid();
        check("symbol on toggling line", 8'h1f, {3'h0, rx_symbol});
        mode = 2'h0;
        repeat (60) @(negedge clk);
        wait_valid();
        check("symbol on still line", 8'h00, {3'h0, rx_symbol});
        check("detect after gap", 8'h00, {7'h00, signal_detect});
        mode = 2'h1;
        i = 0;
        while (signal_detect !== 1'b1 && i < 1000) begin
            @(negedge clk);
            i++;
        end
        check("detect on data", 8'h01, {7'h00, signal_detect});
        mode = 2'h3;
        repeat (150) @(negedge clk);
        i = 0;
        repeat (600) begin
            @(negedge clk);
            if (signal_detect !== 1'b0) i++;
        end
        check("detect under link pulses", 8'h00, 8'(i));
        mode = 2'h1;
    endtask : t_receive

    task automatic t_seed;
        logic [79:0] a;
        logic [79:0] b;
        reset_dut(5'h03);
        repeat (40) begin
            @(negedge clk);
            a = {a[77:0], mlt_pos, mlt_neg};
        end
        reset_dut(5'h1c);
        repeat (40) begin
            @(negedge clk);
            b = {b[77:0], mlt_pos, mlt_neg};
        end
        check("line differs with straps", 8'h01, {7'h00, a !== b});
    endtask : t_seed

    initial begin
        reset_dut(5'h0a);
        t_all_codes();
        t_back_to_back();
        t_receive();
        t_seed();
        print_verdict();
    end
endmodule : fast_ethernet_tx_line_coding_bench

bind fast_ethernet_tx_line_coding line_coding_sva #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
    .clk(clk), .reset(reset), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_en(tx_en),
    .txd(txd), .phy_address_straps(phy_address_straps), .mlt_pos(mlt_pos),
    .mlt_neg(mlt_neg), .rx_level_pos(rx_level_pos), .rx_level_neg(rx_level_neg),
    .signal_detect(signal_detect), .rx_symbol(rx_symbol), .rx_symbol_valid(rx_symbol_valid));
